// ===== core/mrt_pkg.sv
// package for the multimode reload/capture timer
// Function
// - pwm counts down per cycle; first underflow reloads a, then b, a alternately
// - pwm toggle variant inverts pin a each underflow; other variant leaves it
// - pwm underflow sets pending a or b by reload source; software clears
// - pwm interrupt a or b when its enable set and matching reload occurs
// - event mode decrements on selected pin a edge; underflow sets pending a
// - event mode latches pin b rising edge into pending b, interrupt if enabled
// - event mode drives no pwm waveform on pin a
// - capture mode free runs; pin edge copies count into register a or b
// - mode bits: 101/100 pwm, 000/001 event, 010/110/011/111 capture edge select
// - capture mode pin a/b trigger sets pending a/b; interrupts by enables
// - capture underflow latches into run/stop bit, interrupts via enable a
// - run/stop bit gates counting in pwm and event modes
// - 16-bit timer with two 16-bit reload/capture registers
// - timer and both registers hold no reset value until written
package mrt_pkg;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_TIMER = 4'h4;
    localparam logic [3:0] ADDR_REG_A = 4'h8;
    localparam logic [3:0] ADDR_REG_B = 4'hc;
    // ctrl field positions
    localparam int RUN_BIT = 0;
    localparam int MODE_LSB = 1;
    localparam int PEND_A_BIT = 4;
    localparam int PEND_B_BIT = 5;
    localparam int EN_A_BIT = 6;
    localparam int EN_B_BIT = 7;
    localparam logic [15:0] ONES16 = 16'hffff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic mode_select_bit2;
        logic mode_select_bit1;
        logic mode_select_bit0;
        logic run_stop_or_underflow_pending;
        logic pending_flag_a;
        logic pending_flag_b;
        logic irq_enable_a;
        logic irq_enable_b;
    } mrt_ctrl_type;

    typedef struct packed {
        logic timer_pin_a;
        logic timer_pin_b;
    } mrt_pins_type;

    typedef struct packed {
        mrt_ctrl_type ctrl;
        logic [15:0] general_timer;
        logic [15:0] reload_capture_reg_a;
        logic [15:0] reload_capture_reg_b;
        logic next_from_b;
        logic pin_a_out;
        logic [1:0] sync_a;
        logic [1:0] sync_b;
        logic last_a;
        logic last_b;
        logic aw_full;
        logic [3:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mrt_state_type;
endpackage

// ===== core/mrt_timer.sv
// multimode reload/capture timer with axi4-lite register slave
`timescale 1ns/100ps
module mrt_timer import mrt_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire mrt_pins_type pins_in,
    output logic timer_pin_a_out,
    output logic timer_pin_a_oe,
    output logic irq
);
    mrt_state_type s_reg, s_next;

    // mode decode shared by datapath and output logic
    function automatic logic [1:0] mode_of(input mrt_ctrl_type c);
        if (c.mode_select_bit2 && !c.mode_select_bit1) mode_of = 2'd1;
        else if (!c.mode_select_bit2 && !c.mode_select_bit1) mode_of = 2'd2;
        else mode_of = 2'd3;
    endfunction

    function automatic logic [7:0] ctrl_bits(input mrt_ctrl_type c);
        ctrl_bits = 8'h00;
        ctrl_bits[RUN_BIT] = c.run_stop_or_underflow_pending;
        ctrl_bits[MODE_LSB] = c.mode_select_bit0;
        ctrl_bits[MODE_LSB+1] = c.mode_select_bit1;
        ctrl_bits[MODE_LSB+2] = c.mode_select_bit2;
        ctrl_bits[PEND_A_BIT] = c.pending_flag_a;
        ctrl_bits[PEND_B_BIT] = c.pending_flag_b;
        ctrl_bits[EN_A_BIT] = c.irq_enable_a;
        ctrl_bits[EN_B_BIT] = c.irq_enable_b;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] st);
        merge16 = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
    endfunction

    logic [1:0] mode;
    logic a_rise, a_fall, b_rise, b_fall, a_edge_sel, b_edge_sel;
    logic tick, underflow, set_a, set_b, set_run, wr_go, rd_go;
    logic [7:0] cb;

    assign mode = mode_of(s_reg.ctrl);
    // edges seen only on the second synchroniser stage
    assign a_rise = s_reg.sync_a[1] && !s_reg.last_a;
    assign a_fall = !s_reg.sync_a[1] && s_reg.last_a;
    assign b_rise = s_reg.sync_b[1] && !s_reg.last_b;
    assign b_fall = !s_reg.sync_b[1] && s_reg.last_b;
    assign a_edge_sel = s_reg.ctrl.mode_select_bit0 ? a_fall : a_rise;
    assign b_edge_sel = (s_reg.ctrl.mode_select_bit2 || s_reg.ctrl.mode_select_bit0) ? b_fall : b_rise;
    assign wr_go = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
    assign rd_go = s_axi_arvalid && !s_reg.rvalid;

    always_comb begin
        s_next = s_reg;
        tick = 1'b0;
        set_a = 1'b0;
        set_b = 1'b0;
        set_run = 1'b0;
        cb = 8'h00;
        s_next.sync_a = {s_reg.sync_a[0], pins_in.timer_pin_a};
        s_next.sync_b = {s_reg.sync_b[0], pins_in.timer_pin_b};
        s_next.last_a = s_reg.sync_a[1];
        s_next.last_b = s_reg.sync_b[1];
        case (mode)
            2'd1: tick = s_reg.ctrl.run_stop_or_underflow_pending;
            2'd2: tick = s_reg.ctrl.run_stop_or_underflow_pending && a_edge_sel;
            2'd3: tick = 1'b1;
            default: tick = 1'b0;
        endcase
        underflow = tick && (s_reg.general_timer == 16'h0000);
        if (tick) begin
            s_next.general_timer = s_reg.general_timer - 16'h0001;
        end
        case (mode)
            2'd1: begin
                if (underflow) begin
                    s_next.general_timer = s_reg.next_from_b ? s_reg.reload_capture_reg_b : s_reg.reload_capture_reg_a;
                    s_next.next_from_b = !s_reg.next_from_b;
                    set_a = !s_reg.next_from_b;
                    set_b = s_reg.next_from_b;
                    if (s_reg.ctrl.mode_select_bit0) begin
                        s_next.pin_a_out = !s_reg.pin_a_out;
                    end
                end
            end
            2'd2: begin
                set_a = underflow;
                set_b = b_rise;
                s_next.next_from_b = 1'b0;
            end
            2'd3: begin
                set_run = underflow;
                if (a_edge_sel) begin
                    s_next.reload_capture_reg_a = s_reg.general_timer;
                    set_a = 1'b1;
                end
                if (b_edge_sel) begin
                    s_next.reload_capture_reg_b = s_reg.general_timer;
                    set_b = 1'b1;
                end
                s_next.next_from_b = 1'b0;
            end
            default: s_next.next_from_b = 1'b0;
        endcase
        // axi write channel capture
        if (s_axi_awvalid && !s_reg.aw_full) begin
            s_next.aw_full = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.w_full) begin
            s_next.w_full = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end
        if (wr_go) begin
            s_next.aw_full = 1'b0;
            s_next.w_full = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = RESP_OKAY;
            case (s_reg.aw_addr)
                ADDR_CTRL: if (s_reg.w_strb[0]) begin
                    s_next.ctrl.run_stop_or_underflow_pending = s_reg.w_data[RUN_BIT];
                    s_next.ctrl.mode_select_bit0 = s_reg.w_data[MODE_LSB];
                    s_next.ctrl.mode_select_bit1 = s_reg.w_data[MODE_LSB+1];
                    s_next.ctrl.mode_select_bit2 = s_reg.w_data[MODE_LSB+2];
                    s_next.ctrl.pending_flag_a = s_reg.w_data[PEND_A_BIT];
                    s_next.ctrl.pending_flag_b = s_reg.w_data[PEND_B_BIT];
                    s_next.ctrl.irq_enable_a = s_reg.w_data[EN_A_BIT];
                    s_next.ctrl.irq_enable_b = s_reg.w_data[EN_B_BIT];
                    // a control write with byte 0 strobed restarts the pwm alternation at register a
                    s_next.next_from_b = 1'b0;
                end
                ADDR_TIMER: s_next.general_timer = merge16(s_next.general_timer, s_reg.w_data, s_reg.w_strb);
                ADDR_REG_A: s_next.reload_capture_reg_a = merge16(s_next.reload_capture_reg_a, s_reg.w_data, s_reg.w_strb);
                ADDR_REG_B: s_next.reload_capture_reg_b = merge16(s_next.reload_capture_reg_b, s_reg.w_data, s_reg.w_strb);
                default: s_next.bresp = RESP_SLVERR;
            endcase
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        // hardware set wins over a software clear in the same cycle
        if (set_a) s_next.ctrl.pending_flag_a = 1'b1;
        if (set_b) s_next.ctrl.pending_flag_b = 1'b1;
        if (set_run) s_next.ctrl.run_stop_or_underflow_pending = 1'b1;
        // read channel
        if (rd_go) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = RESP_OKAY;
            cb = ctrl_bits(s_reg.ctrl);
            case (s_axi_araddr)
                ADDR_CTRL: s_next.rdata = {24'h00_0000, cb};
                ADDR_TIMER: s_next.rdata = {16'h0000, s_reg.general_timer};
                ADDR_REG_A: s_next.rdata = {16'h0000, s_reg.reload_capture_reg_a};
                ADDR_REG_B: s_next.rdata = {16'h0000, s_reg.reload_capture_reg_b};
                default: begin
                    s_next.rdata = 32'h0000_0000;
                    s_next.rresp = RESP_SLVERR;
                end
            endcase
        end else if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // counter and companions keep their contents
            s_reg.ctrl <= '0;
            s_reg.next_from_b <= 1'b0;
            s_reg.pin_a_out <= 1'b0;
            s_reg.sync_a <= 2'b00;
            s_reg.sync_b <= 2'b00;
            s_reg.last_a <= 1'b0;
            s_reg.last_b <= 1'b0;
            s_reg.aw_full <= 1'b0;
            s_reg.aw_addr <= 4'h0;
            s_reg.w_full <= 1'b0;
            s_reg.w_data <= 32'h0000_0000;
            s_reg.w_strb <= 4'h0;
            s_reg.bvalid <= 1'b0;
            s_reg.bresp <= RESP_OKAY;
            s_reg.rvalid <= 1'b0;
            s_reg.rdata <= 32'h0000_0000;
            s_reg.rresp <= RESP_OKAY;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    assign s_axi_awready = !s_reg.aw_full;
    assign s_axi_wready = !s_reg.w_full;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = !s_reg.rvalid;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign timer_pin_a_out = s_reg.pin_a_out;
    // pin a is only driven in pwm mode
    assign timer_pin_a_oe = (mode == 2'd1);
    assign irq = (s_reg.ctrl.irq_enable_a && (s_reg.ctrl.pending_flag_a
                 || (mode == 2'd3 && s_reg.ctrl.run_stop_or_underflow_pending)))
                 || (s_reg.ctrl.irq_enable_b && s_reg.ctrl.pending_flag_b);

    a_pwm_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && mode == 2'd1 && underflow && s_reg.ctrl.mode_select_bit0 |=> timer_pin_a_out != $past(timer_pin_a_out))
        else $error("pin a did not toggle");
    a_pwm_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && mode == 2'd1 && underflow && !s_reg.next_from_b && !wr_go
        |=> s_reg.general_timer == $past(s_reg.reload_capture_reg_a) && s_reg.next_from_b)
        else $error("reload a missing");
    a_pend_set: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && set_a |=> s_reg.ctrl.pending_flag_a)
        else $error("pending a not set");
    a_event_nodrive: assert property (@(posedge aclk) disable iff (!aresetn)
        mode == 2'd2 |-> !timer_pin_a_oe)
        else $error("pin a driven in event mode");
    a_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && mode == 2'd3 && a_edge_sel && !wr_go |=> s_reg.reload_capture_reg_a == $past(s_reg.general_timer))
        else $error("capture a wrong");
    a_capture_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && mode == 2'd3 && underflow && !wr_go |=> s_reg.general_timer == ONES16 && s_reg.ctrl.run_stop_or_underflow_pending)
        else $error("no wrap");
    a_run_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && mode != 2'd3 && !s_reg.ctrl.run_stop_or_underflow_pending && !wr_go
        |=> s_reg.general_timer === $past(s_reg.general_timer))
        else $error("timer moved while stopped");
    a_event_b: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && mode == 2'd2 && b_rise |=> s_reg.ctrl.pending_flag_b ##0 (irq || !s_reg.ctrl.irq_enable_b))
        else $error("pin b edge lost");
endmodule

// ===== test/mrt_pin_model.sv
// far-side pin model: levels on timer pin a and timer pin b
`timescale 1ns/100ps
module mrt_pin_model (
    input wire logic aclk,
    output logic pin_a,
    output logic pin_b
);
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end
    // settle both pins, long enough for the input synchronisers
    task automatic idle(input logic pa, input logic pb);
        @(posedge aclk);
        pin_a <= pa;
        pin_b <= pb;
        repeat (8) @(posedge aclk);
    endtask
    // full pulse on one pin, so either edge polarity sees exactly one edge
    task automatic pulse(input logic on_b);
        @(posedge aclk);
        if (on_b) pin_b <= 1'b1;
        else pin_a <= 1'b1;
        repeat (5) @(posedge aclk);
        pin_a <= 1'b0;
        pin_b <= 1'b0;
        repeat (5) @(posedge aclk);
    endtask
    // edge on a, gap cycles later edge on b, then both back to rest
    task automatic edges(input logic pa, input logic pb, input int gap);
        @(posedge aclk);
        pin_a <= pa;
        repeat (gap) @(posedge aclk);
        pin_b <= pb;
        repeat (8) @(posedge aclk);
        pin_a <= ~pa;
        pin_b <= ~pb;
        repeat (8) @(posedge aclk);
    endtask
endmodule

// ===== test/mrt_timer_tb.sv
// self-checking bench for the multimode reload/capture timer
`timescale 1ns/100ps
module mrt_timer_tb import mrt_pkg::*;;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, pa_out, pa_oe, irq, ma, mb, pa, pb;
    logic [3:0] awaddr, araddr;
    logic [1:0] bresp, rresp;
    logic [31:0] wdata, rdata, d, d2, g;
    logic en;
    logic [3:0] strb;
    logic [7:0] ev [2] = '{8'h41, 8'h43};
    logic [7:0] cm [4] = '{8'h44, 8'h4c, 8'h46, 8'h4e};
    int fails, checked;
    mrt_pins_type pins;
    // pin a is shared: the design owns it while its enable is high
    assign pins.timer_pin_a = pa_oe ? pa_out : ma;
    assign pins.timer_pin_b = mb;
    mrt_pin_model far (.aclk(aclk), .pin_a(ma), .pin_b(mb));
    mrt_timer uut (.aclk(aclk), .aresetn(aresetn), .clk_en(en), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pins_in(pins), .timer_pin_a_out(pa_out), .timer_pin_a_oe(pa_oe), .irq(irq));
    initial aclk = 1'b0;
    always #2.5 aclk = ~aclk;
    task automatic results();
        if (fails == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic lim(input int n, input int m);
        if (n >= m) begin
            fails++;
            results();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er = RESP_OKAY);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        lim(n, 50);
        chk("bresp", bresp, er);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v, input logic [1:0] er = RESP_OKAY);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        v = rdata;
        lim(n, 50);
        chk("rresp", rresp, er);
    endtask
    // flags are sticky, so polling the control word cannot miss one
    task automatic poll(input logic [31:0] m);
        int n;
        n = 0;
        do begin
            rd(ADDR_CTRL, d);
            n++;
        end while ((d & m) == 0 && n < 40);
        lim(n, 40);
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        en = 1'b1;
        strb = 4'hf;
        fails = 0;
        checked = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_CTRL, d);
        chk("ctrl reset", d, 8'h00);
        chk("irq reset", irq, 1'b0);
        rd(4'h2, d, RESP_SLVERR);
        chk("unmapped data", d, 8'h00);
        wr(4'h2, 8'h01, RESP_SLVERR);
        wr(ADDR_REG_A, 16'h0014);
        wr(ADDR_REG_B, 16'h0028);
        wr(ADDR_TIMER, 16'h0003);
        wr(ADDR_CTRL, 8'h4b);
        poll(8'h10);
        chk("pwm flags a", d, 8'h5b);
        chk("pwm pin a", pa_out, 1'b1);
        chk("pwm oe", pa_oe, 1'b1);
        chk("pwm irq a", irq, 1'b1);
        poll(8'h20);
        chk("pwm flags b", d, 8'h7b);
        chk("pwm pin b", pa_out, 1'b0);
        wr(ADDR_CTRL, 8'h8b);
        poll(8'h10);
        chk("irq masked", irq, 1'b0);
        poll(8'h20);
        chk("flags both", d, 8'hbb);
        chk("irq b", irq, 1'b1);
        wr(ADDR_CTRL, 8'h08);
        wr(ADDR_TIMER, 16'h1234);
        repeat (10) @(posedge aclk);
        rd(ADDR_TIMER, d);
        chk("pwm stopped", d, 16'h1234);
        strb <= 4'h2;
        wr(ADDR_TIMER, 32'h0000_5678);
        strb <= 4'hf;
        rd(ADDR_TIMER, d);
        chk("byte strobe", d, 16'h5634);
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_CTRL, 8'h00);
            wr(ADDR_TIMER, 16'h0002);
            far.pulse(1'b0);
            wr(ADDR_CTRL, ev[i]);
            far.pulse(1'b0);
            far.pulse(1'b0);
            rd(ADDR_TIMER, d);
            chk("event count", d, 16'h0000);
            chk("event oe", pa_oe, 1'b0);
            chk("event irq idle", irq, 1'b0);
            far.pulse(1'b0);
            rd(ADDR_CTRL, d);
            chk("event underflow", d, ev[i] | 8'h10);
            chk("event irq", irq, 1'b1);
            far.pulse(1'b1);
            rd(ADDR_CTRL, d);
            chk("event pin b", d, ev[i] | 8'h30);
        end
        for (int i = 0; i < 4; i++) begin
            pa = (i < 2);
            pb = (i == 0);
            far.idle(!pa, !pb);
            wr(ADDR_CTRL, cm[i]);
            wr(ADDR_TIMER, 16'h8000);
            far.edges(pa, pb, 7);
            rd(ADDR_REG_A, d);
            rd(ADDR_REG_B, d2);
            chk("capture gap", d - d2, 32'h0000_0007);
            rd(ADDR_CTRL, d);
            chk("capture flags", d, cm[i] | 8'h30);
            chk("capture irq", irq, 1'b1);
        end
        wr(ADDR_CTRL, 8'h44);
        wr(ADDR_TIMER, 16'h0004);
        poll(8'h01);
        chk("underflow flags", d, 8'h45);
        chk("underflow irq", irq, 1'b1);
        rd(ADDR_TIMER, d);
        chk("timer wrap", d[15:12], 4'hf);
        // same read spacing with and without a freeze: twenty frozen edges must not count
        rd(ADDR_TIMER, d);
        rd(ADDR_TIMER, d2);
        g = d - d2;
        rd(ADDR_TIMER, d);
        en <= 1'b0;
        repeat (20) @(posedge aclk);
        en <= 1'b1;
        rd(ADDR_TIMER, d2);
        chk("clk_en freeze", d - d2, g);
        results();
    end
endmodule
